// ---- hw/ssp_port.sv ----
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ssp_port (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // one-cycle ack
  input wire logic serial_clock_pin_i, // clock from master
  output logic serial_clock_pin_o, // clock as master
  output logic serial_clock_pin_oe_o, // clock drive enable
  input wire logic select_pin_i, // select from master
  output logic select_pin_o, // select as master
  output logic select_pin_oe_o, // select drive enable
  input wire logic miso_i, // master-in line level
  output logic miso_o, // slave data out
  output logic miso_oe_o, // slave data enable
  input wire logic mosi_i, // master-out line level
  output logic mosi_o, // master data out
  output logic mosi_oe_o // master data enable
);
  // ***************************************
  // declarations
  // ***************************************
  ssp_fifo_if tx_q ();
  ssp_fifo_if rx_q ();
  logic [15:0] cr0;
  logic [3:0] cr1;
  logic [7:0] cpsr;
  logic [3:0] imsc;
  logic ror;
  logic [3:0] data_size_select;
  logic [1:0] frame_format;
  logic [7:0] clock_rate_field;
  logic port_en;
  logic slave_mode;
  logic slave_od;
  logic mst_en;
  logic eff_clock_polarity;
  logic eff_clock_phase;
  logic sel_act;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic [4:0] status;
  logic [3:0] ris;
  ssp_pkg::ssp_state_e state;
  logic [6:0] pre_lim;
  logic [6:0] pre_cnt;
  logic [7:0] scr_cnt;
  logic half_tick;
  logic [4:0] hcnt;
  logic m_cap;
  logic [15:0] txsr;
  logic [15:0] rxsr;
  logic mst_load;
  logic mst_done;
  logic slv_sel;
  logic slv_sel_q;
  logic sclk_prev;
  logic slv_edge;
  logic s_cap;
  logic [4:0] bits;
  logic [15:0] stx;
  logic [15:0] srx;
  logic slv_done;
  logic slv_start;
  logic [15:0] tx_word;

  // ***************************************
  // queues
  // ***************************************
  ssp_fifo u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port(tx_q.store)
  );
  ssp_fifo u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port(rx_q.store)
  );

  // ***************************************
  // control decode
  // ***************************************
  // clamp unsupported sizes
  assign data_size_select = (cr0[ssp_pkg::DSS_LSB +: 4] < ssp_pkg::DSS_MIN) ?
               ssp_pkg::DSS_MIN : cr0[ssp_pkg::DSS_LSB +: 4];
  assign frame_format = cr0[ssp_pkg::FRF_LSB +: 2];
  assign clock_rate_field = cr0[ssp_pkg::SCR_LSB +: 8];
  assign port_en = cr1[ssp_pkg::SSE_BIT];
  assign slave_mode = cr1[ssp_pkg::MS_BIT];
  assign slave_od = cr1[ssp_pkg::SOD_BIT];
  assign mst_en = port_en & ~slave_mode;
  assign eff_clock_polarity = (frame_format == ssp_pkg::FRF_SPI) ? cr0[ssp_pkg::CLOCK_POLARITY_BIT] : 1'h0;
  assign eff_clock_phase = (frame_format == ssp_pkg::FRF_SPI) ? cr0[ssp_pkg::CLOCK_PHASE_BIT] :
                    (frame_format == ssp_pkg::FRF_TI);
  assign sel_act = (frame_format == ssp_pkg::FRF_TI);

  // ***************************************
  // bus slave
  // ***************************************
  // request is taken once; ack drops the cycle after
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;

  // byte lane mask
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
  end

  // ack and read data, both registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cr0 <= ssp_pkg::CR0_RESET;
      cr1 <= ssp_pkg::CR1_RESET;
      cpsr <= ssp_pkg::CPSR_RESET;
      imsc <= ssp_pkg::IMSC_RESET;
    end else if (bus_wr) begin
      // byte lanes merged per register, unused upper bits dropped
      if (wb_adr_i == ssp_pkg::OFF_CR0) begin
        cr0 <= (cr0 & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (wb_adr_i == ssp_pkg::OFF_CR1) begin
        cr1 <= (cr1 & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
      end
      if (wb_adr_i == ssp_pkg::OFF_CPSR) begin
        cpsr <= (cpsr & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
      end
      if (wb_adr_i == ssp_pkg::OFF_IMSC) begin
        imsc <= (imsc & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
      end
    end
  end

  // status and raw interrupt view
  always_comb begin
    status = 5'h00;
    status[ssp_pkg::SR_TFE] = tx_q.empty;
    status[ssp_pkg::SR_TNF] = ~tx_q.full;
    status[ssp_pkg::SR_RNE] = ~rx_q.empty;
    status[ssp_pkg::SR_RFF] = rx_q.full;
    status[ssp_pkg::SR_BSY] = (state != ssp_pkg::ST_IDLE) | slv_sel_q;
    ris = 4'h0;
    ris[ssp_pkg::RIS_ROR] = ror;
    ris[ssp_pkg::RIS_RX] = (rx_q.count >= ssp_pkg::HALF_LEVEL);
    ris[ssp_pkg::RIS_TX] = (tx_q.count <= ssp_pkg::HALF_LEVEL);
  end

  // read mux; unmapped and clear register read zero
  always_comb begin
    case (wb_adr_i)
      ssp_pkg::OFF_CR0: rdata = {16'h0, cr0};
      ssp_pkg::OFF_CR1: rdata = {28'h0, cr1};
      // empty queue reads zero, never stale or unwritten storage
      ssp_pkg::OFF_DR: rdata = rx_q.empty ? 32'h0 : {16'h0, rx_q.rdata};
      ssp_pkg::OFF_SR: rdata = {27'h0, status};
      ssp_pkg::OFF_CPSR: rdata = {24'h0, cpsr};
      ssp_pkg::OFF_IMSC: rdata = {28'h0, imsc};
      ssp_pkg::OFF_RIS: rdata = {28'h0, ris};
      ssp_pkg::OFF_MIS: rdata = {28'h0, ris & imsc};
      default: rdata = 32'h0;
    endcase
  end

  // data register feeds and drains queues
  assign tx_q.push = bus_wr & (wb_adr_i == ssp_pkg::OFF_DR) & (|wb_sel_i[1:0]);
  assign tx_q.wdata = wb_dat_i[15:0];
  assign rx_q.pop = bus_rd & (wb_adr_i == ssp_pkg::OFF_DR);

  // overrun latch; a new overrun beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ror <= 1'h0;
    end else if (rx_q.push & rx_q.full) begin
      ror <= 1'h1;
    end else if (bus_wr & (wb_adr_i == ssp_pkg::OFF_ICR) & wb_sel_i[0]
                 & wb_dat_i[ssp_pkg::RIS_ROR]) begin
      ror <= 1'h0;
    end
  end

  // ***************************************
  // bit clock generator
  // ***************************************
  // odd divisors behave as the next lower even one
  assign pre_lim = (cpsr[7:1] == 7'h00) ? ssp_pkg::PRE_MIN : cpsr[7:1];
  // half bit is divisor/2 times rate+1
  assign half_tick = (state != ssp_pkg::ST_IDLE) & (pre_cnt == pre_lim - 7'h01)
                     & (scr_cnt == clock_rate_field);

  always_ff @(posedge clk_i) begin
    if (rst_i || state == ssp_pkg::ST_IDLE) begin
      pre_cnt <= 7'h00;
      scr_cnt <= 8'h00;
    end else if (pre_cnt == pre_lim - 7'h01) begin
      pre_cnt <= 7'h00;
      scr_cnt <= (scr_cnt == clock_rate_field) ? 8'h00 : scr_cnt + 8'h01;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // ***************************************
  // master engine
  // ***************************************
  assign mst_load = (state == ssp_pkg::ST_IDLE) & mst_en & ~tx_q.empty;
  assign mst_done = (state == ssp_pkg::ST_HOLD) & half_tick;
  // even half bits leave idle level
  assign m_cap = ~hcnt[0] ^ eff_clock_phase;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ssp_pkg::ST_IDLE;
      hcnt <= 5'h00;
      txsr <= 16'h0000;
      rxsr <= 16'h0000;
      serial_clock_pin_o <= 1'h0;
      select_pin_o <= 1'h1;
      mosi_o <= 1'h0;
    end else begin
      case (state)
        ssp_pkg::ST_IDLE: begin
          serial_clock_pin_o <= eff_clock_polarity;
          select_pin_o <= ~sel_act;
          hcnt <= 5'h00;
          if (mst_load) begin
            txsr <= tx_q.rdata;
            rxsr <= 16'h0000;
            mosi_o <= tx_q.rdata[data_size_select];
            select_pin_o <= sel_act;
            state <= ssp_pkg::ST_SETUP;
          end
        end
        ssp_pkg::ST_SETUP: begin
          if (half_tick) begin
            state <= ssp_pkg::ST_SHIFT;
            if (frame_format == ssp_pkg::FRF_TI) begin
              select_pin_o <= ~sel_act;
            end
          end
        end
        ssp_pkg::ST_SHIFT: begin
          if (half_tick) begin
            serial_clock_pin_o <= ~serial_clock_pin_o;
            hcnt <= hcnt + 5'h01;
            if (m_cap) begin
              rxsr <= {rxsr[14:0], miso_i};
            end else if (hcnt != 5'h00) begin
              txsr <= {txsr[14:0], 1'h0};
              mosi_o <= txsr[data_size_select - 4'h1];
            end
            if (hcnt == {data_size_select, 1'h1}) begin
              state <= ssp_pkg::ST_HOLD;
            end
          end
        end
        ssp_pkg::ST_HOLD: begin
          if (half_tick) begin
            select_pin_o <= ~sel_act;
            state <= ssp_pkg::ST_IDLE;
          end
        end
        default: state <= ssp_pkg::ST_IDLE;
      endcase
    end
  end

  // master pins driven only in master mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_clock_pin_oe_o <= 1'h0;
      select_pin_oe_o <= 1'h0;
      mosi_oe_o <= 1'h0;
    end else begin
      serial_clock_pin_oe_o <= mst_en;
      select_pin_oe_o <= mst_en;
      mosi_oe_o <= mst_en;
    end
  end

  // ***************************************
  // slave engine
  // ***************************************
  // select qualifies master data
  assign slv_sel = port_en & slave_mode & (select_pin_i == sel_act);
  assign slv_edge = serial_clock_pin_i != sclk_prev;
  assign s_cap = (serial_clock_pin_i != eff_clock_polarity) ^ eff_clock_phase;
  assign slv_done = slv_sel & slv_sel_q & slv_edge & s_cap & (bits == {1'h0, data_size_select});
  assign slv_start = slv_sel & (~slv_sel_q | slv_done);
  // an empty queue sends zeros rather than stalling the master
  assign tx_word = tx_q.empty ? 16'h0000 : tx_q.rdata;
  assign tx_q.pop = mst_load | (slv_start & ~tx_q.empty);

  // receive queue fed by either engine
  assign rx_q.push = mst_done | slv_done;
  assign rx_q.wdata = mst_done ? rxsr : {srx[14:0], mosi_i};

  // slave times data from master clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev <= 1'h0;
      slv_sel_q <= 1'h0;
      bits <= 5'h00;
      stx <= 16'h0000;
      srx <= 16'h0000;
      miso_o <= 1'h0;
    end else begin
      sclk_prev <= serial_clock_pin_i;
      slv_sel_q <= slv_sel;
      if (!slv_sel) begin
        bits <= 5'h00;
      end else if (slv_start) begin
        bits <= 5'h00;
        stx <= tx_word;
        srx <= 16'h0000;
        miso_o <= tx_word[data_size_select];
      end else if (slv_edge) begin
        if (s_cap) begin
          srx <= {srx[14:0], mosi_i};
          bits <= bits + 5'h01;
        end else if (bits != 5'h00) begin
          stx <= {stx[14:0], 1'h0};
          miso_o <= stx[data_size_select - 4'h1];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_oe_o <= 1'h0;
    end else begin
      miso_oe_o <= slv_sel & ~slave_od;
    end
  end

  // ***************************************
  // checks
  // ***************************************
  // idle clock level
  clk_idle_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ssp_pkg::ST_IDLE) |=> (serial_clock_pin_o == $past(eff_clock_polarity)))
    else $error("clock not at idle level");
  clk_quiet_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ssp_pkg::ST_SETUP || state == ssp_pkg::ST_HOLD)
      |=> $stable(serial_clock_pin_o))
    else $error("clock toggled outside frame");
  sel_frame_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ssp_pkg::ST_SHIFT && frame_format == ssp_pkg::FRF_SPI) |-> !select_pin_o)
    else $error("select not asserted in frame");
  mst_sample_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ssp_pkg::ST_SHIFT && half_tick && m_cap) |=> (rxsr[0] == $past(miso_i)))
    else $error("master-in bit not captured");
  slv_sample_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (slv_sel && !slv_start && slv_edge && s_cap) |=> (srx[0] == $past(mosi_i)))
    else $error("master-out bit not captured");
  miso_release_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !slv_sel |=> !miso_oe_o)
    else $error("master-in driven while unselected");
  mosi_drive_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      mst_en ##1 mst_en |-> mosi_oe_o && serial_clock_pin_oe_o)
    else $error("master lines not driven");
  tx_push_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_q.push && !tx_q.full && !tx_q.pop) |=> (tx_q.count == $past(tx_q.count) + 4'h1))
    else $error("data write not queued");
  reset_view_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (status[1:0] == ssp_pkg::SR_RESET_LOW && ris == ssp_pkg::RIS_RESET))
    else $error("wrong status after reset");
  mis_read_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_rd && wb_adr_i == ssp_pkg::OFF_MIS) |=> (wb_dat_o[3:0] == $past(ris & imsc)))
    else $error("masked status wrong");
  frame_len_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (state == ssp_pkg::ST_SHIFT) |-> (hcnt <= {data_size_select, 1'h1}))
    else $error("frame longer than size");
endmodule : ssp_port
`default_nettype wire

// ---- common/ssp_pkg.sv ----
`default_nettype none
package ssp_pkg;
  // ***************************************
  // sizes
  // ***************************************
  localparam int WORD_W = 16;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [3:0] HALF_LEVEL = 4'h4;
  // ***************************************
  // register byte offsets
  // ***************************************
  localparam logic [7:0] OFF_CR0 = 8'h00;
  localparam logic [7:0] OFF_CR1 = 8'h04;
  localparam logic [7:0] OFF_DR = 8'h08;
  localparam logic [7:0] OFF_SR = 8'h0C;
  localparam logic [7:0] OFF_CPSR = 8'h10;
  localparam logic [7:0] OFF_IMSC = 8'h14;
  localparam logic [7:0] OFF_RIS = 8'h18;
  localparam logic [7:0] OFF_MIS = 8'h1C;
  localparam logic [7:0] OFF_ICR = 8'h20;
  // ***************************************
  // field positions
  // ***************************************
  localparam int DSS_LSB = 0;
  localparam int FRF_LSB = 4;
  localparam int CLOCK_POLARITY_BIT = 6;
  localparam int CLOCK_PHASE_BIT = 7;
  localparam int SCR_LSB = 8;
  localparam int SSE_BIT = 1;
  localparam int MS_BIT = 2;
  localparam int SOD_BIT = 3;
  localparam int SR_TFE = 0;
  localparam int SR_TNF = 1;
  localparam int SR_RNE = 2;
  localparam int SR_RFF = 3;
  localparam int SR_BSY = 4;
  localparam int RIS_ROR = 0;
  localparam int RIS_RT = 1;
  localparam int RIS_RX = 2;
  localparam int RIS_TX = 3;
  // ***************************************
  // codes and reset values
  // ***************************************
  localparam logic [1:0] FRF_SPI = 2'h0;
  localparam logic [1:0] FRF_TI = 2'h1;
  localparam logic [3:0] DSS_MIN = 4'h3;
  localparam logic [6:0] PRE_MIN = 7'h01;
  localparam logic [15:0] CR0_RESET = 16'h0000;
  localparam logic [3:0] CR1_RESET = 4'h0;
  localparam logic [7:0] CPSR_RESET = 8'h00;
  localparam logic [3:0] IMSC_RESET = 4'h0;
  localparam logic [1:0] SR_RESET_LOW = 2'h3;
  localparam logic [3:0] RIS_RESET = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b10,
    ST_HOLD = 2'b11
  } ssp_state_e;
endpackage : ssp_pkg
`default_nettype wire

// ---- common/ssp_fifo_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// fifo push/pop side shared by the port and its queues
interface ssp_fifo_if;
  logic push;
  logic [ssp_pkg::WORD_W-1:0] wdata;
  logic pop;
  logic [ssp_pkg::WORD_W-1:0] rdata;
  logic full;
  logic empty;
  logic [3:0] count;
  modport owner (output push, wdata, pop, input rdata, full, empty, count);
  modport store (input push, wdata, pop, output rdata, full, empty, count);
endinterface : ssp_fifo_if
`default_nettype wire

// ---- hw/ssp_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssp_fifo (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  ssp_fifo_if.store port // queue access
);
  logic [ssp_pkg::WORD_W-1:0] mem [0:(1<<ssp_pkg::FIFO_AW)-1];
  logic [ssp_pkg::FIFO_AW-1:0] wr_ptr;
  logic [ssp_pkg::FIFO_AW-1:0] rd_ptr;
  logic [3:0] count;
  logic do_push;
  logic do_pop;

  // overfull pushes and empty pops are dropped silently
  assign do_push = port.push & ~port.full;
  assign do_pop = port.pop & ~port.empty;

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= port.wdata;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 4'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 3'h1;
      end
      if (do_push & ~do_pop) begin
        count <= count + 4'h1;
      end else if (do_pop & ~do_push) begin
        count <= count - 4'h1;
      end
    end
  end

  // head word is visible without a pop
  assign port.rdata = mem[rd_ptr];
  assign port.full = (count == ssp_pkg::FIFO_FULL);
  assign port.empty = (count == 4'h0);
  assign port.count = count;
endmodule : ssp_fifo
`default_nettype wire

// ---- sim/ssp_remote_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// remote slave on the serial bus
// ****
module ssp_remote_slave (
  input wire logic sclk_i, // clock from master
  input wire logic sel_n_i, // select, low active
  input wire logic mosi_i, // data from master
  input wire logic clock_polarity_i, // idle clock level
  input wire logic clock_phase_i, // capture on trailing edge
  input wire logic [4:0] bits_i, // frame width
  input wire logic [15:0] reply_i, // word sent back
  output logic miso_o, // data to master
  output logic [15:0] got_o // word received
);
  logic [15:0] sh;
  initial begin
    miso_o = 1'b0;
    got_o = 16'h0000;
    sh = 16'h0000;
  end
  always @(negedge sel_n_i) begin
    sh = reply_i << (16 - bits_i);
    got_o = 16'h0000;
    if (!clock_phase_i) begin
      miso_o = sh[15];
      sh = sh << 1;
    end
  end
  always @(sclk_i) begin
    if (!sel_n_i) begin
      if ((sclk_i != clock_polarity_i) != clock_phase_i) begin
        got_o = {got_o[14:0], mosi_i};
      end else begin
        miso_o = sh[15];
        sh = sh << 1;
      end
    end
  end
  // released line shows the last driven bit inverted
  always @(posedge sel_n_i) begin
    miso_o = ~miso_o;
  end
endmodule : ssp_remote_slave
`default_nettype wire

// ---- sim/tb_ssp_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_ssp_port;
  logic clk_i, rst_i, cyc, stb, we, ack, sck_o, sck_oe, sel_o, sel_oe, so, so_oe, mo, mo_oe;
  logic sel_in, clock_polarity, clock_phase, watch, pm;
  logic [7:0] adr, clock_rate_field, cpsr;
  logic [31:0] dat, rdat, q, w;
  logic [15:0] reply, got, mask, tx;
  logic [4:0] bits;
  logic [7:0] offs [4] = '{ssp_pkg::OFF_CR0, ssp_pkg::OFF_CR1, ssp_pkg::OFF_CPSR, ssp_pkg::OFF_IMSC};
  logic [31:0] msk [4] = '{32'h0000FFFF, 32'h0000000F, 32'h000000FF, 32'h0000000F};
  wire sck_w = sck_oe ? sck_o : clock_polarity;
  wire sel_w = sel_oe ? sel_o : sel_in;
  int errors = 0, samples_checked = 0, seed = 32'h96c0, flen, h, n;
  logic [31:0] exp_q [$];
  // ****
  // clock, design and partner
  // ****
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ssp_port i_ssp_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_o(sck_oe), .select_pin_i(sel_w), .select_pin_o(sel_o),
    .select_pin_oe_o(sel_oe), .miso_i(pm), .miso_o(so), .miso_oe_o(so_oe),
    .mosi_i(mo), .mosi_o(mo), .mosi_oe_o(mo_oe));
  ssp_remote_slave i_ssp_remote_slave (.sclk_i(sck_w), .sel_n_i(sel_w), .mosi_i(mo),
    .clock_polarity_i(clock_polarity), .clock_phase_i(clock_phase), .bits_i(bits), .reply_i(reply), .miso_o(pm), .got_o(got));
  // ****
  // checking and bus tasks
  // ****
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // single classic cycle, held until ack is sampled
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      errors++;
      end_sim();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", q, e);
  endtask : rd
  // frame length and idle clock level seen on the wires
  always @(posedge clk_i) begin
    if (!sel_w) flen <= flen + 1;
    if (watch && sel_w && sck_oe) chk("idle clock", 32'(sck_o), 32'(clock_polarity));
  end
  // ****
  // main sequence
  // ****
  initial begin
    {rst_i, sel_in} = 2'b11;
    {cyc, stb, we, clock_polarity, clock_phase, watch} = 6'h00;
    adr = 8'h00;
    dat = 32'h0;
    reply = 16'h0000;
    bits = 5'h08;
    flen = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, skipping the write-only clear place
    for (int i = 0; i < 10; i++) begin
      if (i != 8) rd(8'(i * 4), (i == 3) ? 32'h3 : (i == 6) ? 32'h8 : 32'h0);
    end
    bus(1'b1, ssp_pkg::OFF_SR, 32'hFFFFFFFF);
    rd(ssp_pkg::OFF_SR, 32'h3);
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    rd(8'h24, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      bus(1'b1, offs[i], w);
      rd(offs[i], w & msk[i]);
    end
    bus(1'b1, ssp_pkg::OFF_CR1, 32'h0);
    bus(1'b1, ssp_pkg::OFF_CR0, 32'h0);
    // masked view is raw and mask; clearing leaves the level source
    bus(1'b1, ssp_pkg::OFF_IMSC, 32'hF);
    rd(ssp_pkg::OFF_MIS, 32'h8);
    bus(1'b1, ssp_pkg::OFF_ICR, 32'hF);
    rd(ssp_pkg::OFF_RIS, 32'h8);
    bus(1'b1, ssp_pkg::OFF_IMSC, 32'h0);
    rd(ssp_pkg::OFF_MIS, 32'h0);
    // slave: select high is idle for the plain format, selection for the other
    bus(1'b1, ssp_pkg::OFF_CR1, 32'h6);
    rd(ssp_pkg::OFF_SR, 32'h3);
    chk("miso drive", {so_oe, mo_oe}, 32'h0);
    bus(1'b1, ssp_pkg::OFF_CR1, 32'h0);
    bus(1'b1, ssp_pkg::OFF_CR0, 32'h17);
    bus(1'b1, ssp_pkg::OFF_CR1, 32'h6);
    rd(ssp_pkg::OFF_SR, 32'h13);
    chk("miso drive", {so_oe, mo_oe}, 32'h2);
    chk("slave out", 32'(so), 32'h0);
    bus(1'b1, ssp_pkg::OFF_CR1, 32'h0);
    // master frames in all four clock modes with random size and rate
    for (int m = 0; m < 4; m++) begin
      {clock_phase, clock_polarity} = 2'(m);
      bits = 5'(4 + ({$random(seed)} % 13));
      clock_rate_field = 8'({$random(seed)} % 3);
      cpsr = 8'(2 + 2 * clock_polarity);
      h = (1 + clock_polarity) * (clock_rate_field + 1);
      mask = 16'((32'h1 << bits) - 1);
      reply = 16'($random(seed));
      tx = 16'($random(seed));
      bus(1'b1, ssp_pkg::OFF_CR0, {16'h0, clock_rate_field, clock_phase, clock_polarity, 2'b00, 4'(bits - 1)});
      bus(1'b1, ssp_pkg::OFF_CPSR, {24'h0, cpsr});
      bus(1'b1, ssp_pkg::OFF_DR, {16'h0, tx});
      exp_q.push_back({16'h0, reply & mask});
      flen = 0;
      watch = 1'b1;
      bus(1'b1, ssp_pkg::OFF_CR1, 32'h2);
      n = 0;
      do begin
        bus(1'b0, ssp_pkg::OFF_SR, 32'h0);
        n++;
      end while ((q[4] !== 1'b0 || q[2] !== 1'b1) && n < 300);
      if (n >= 300) begin
        errors++;
        end_sim();
      end
      rd(ssp_pkg::OFF_DR, exp_q.pop_front());
      chk("frame length", 32'(flen), 32'((2 * bits + 2) * h));
      chk("mosi word", 32'(got), 32'(tx & mask));
      watch = 1'b0;
      bus(1'b1, ssp_pkg::OFF_CR1, 32'h0);
    end
    rd(ssp_pkg::OFF_SR, 32'h3);
    end_sim();
  end
endmodule : tb_ssp_port
`default_nettype wire
